// file: fbec_regs.vh
// Command codes, unlock patterns and timing constants for the decoder
//
// What this block and its host do
// [R1] Host raises accel supply before accelerated command
// [R2] Accelerated command only in bypass or read
// [R3] Accelerated program skips protection unless lock set
// [R4] Accelerated command refused while secured region enabled
// [R5] Two unlocks then 20h enter fast-program mode
// [R6] Fast program: A0h then address and data
// [R7] 90h then 00h leaves fast-program mode
// [R8] Bypass 80h,10h chip erase; no suspend
// [R9] Bypass entry and program ignored when secured
// [R10] Chip erase: unlock, 80h, unlock, 10h
// [R11] Chip erase spares protected sectors, preprograms first
// [R12] Hardware reset aborts embedded operation at once
// [R13] Erase starts at last write rising edge
// [R14] Busy reported on poll, toggles and ready pin
// [R15] During erase only suspend is accepted
// [R16] After erase, array valid only after address change
// [R17] Sector erase ends 30h; address on falling edge
// [R18] Host adds sectors within 80 us each
// [R19] Sector erase starts 80 us after last write
// [R20] Host blocks interrupts while loading sectors
// [R21] Sector erase touches only selected unprotected sectors
// [R22] Suspend and resume alternate freely in sector erase; the code refuses resume while the secured region is enabled
// [R23] Word program: unlock, A0h, address and data
// [R24] Bad sequence aborts to read array unchanged
`ifndef FBEC_REGS_VH
`define FBEC_REGS_VH

// ----------------------------------------
// Unlock cycles (low address bits, data)
// ----------------------------------------
`define FBEC_UNLK_A1 12'h555
`define FBEC_UNLK_A2 12'h2aa
`define FBEC_UNLK_D1 8'haa
`define FBEC_UNLK_D2 8'h55

// ----------------------------------------
// Command codes
// ----------------------------------------
`define FBEC_CMD_BYP 8'h20
`define FBEC_CMD_PGM 8'ha0
`define FBEC_CMD_ACC 8'ha0
`define FBEC_CMD_ESET 8'h80
`define FBEC_CMD_CHIP 8'h10
`define FBEC_CMD_SECT 8'h30
`define FBEC_CMD_RESUME 8'h30
`define FBEC_CMD_SUSP 8'hb0
`define FBEC_CMD_BRST1 8'h90
`define FBEC_CMD_BRST2 8'h00
`define FBEC_CMD_RESET 8'hf0

// ----------------------------------------
// Erase phase codes
// ----------------------------------------
`define FBEC_PH_IDLE 2'h0
`define FBEC_PH_PREP 2'h1
`define FBEC_PH_ERASE 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define FBEC_CLK_MHZ 100
`define FBEC_SE_WIN_US 80
`define FBEC_PROG_CYC 100
`define FBEC_PREP_CYC 1000
`define FBEC_ERASE_CYC 2000

`endif

// file: fbec_sync.v
// Two-stage synchroniser for asynchronous pin groups
`timescale 1ns/1ps
module fbec_sync #(
   parameter W = 1,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Pins and synchronised copy
   input wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge clk_in) begin
      if (rst_in) begin
         meta_q <= RST;
         sync_q <= RST;
      end else begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end

   assign q_out = sync_q;
endmodule

// file: fbec_decoder.v
// Command decoder for the fast-program, chip erase and sector erase paths
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "fbec_regs.vh"
module fbec_decoder #(
   parameter ADDR_W = 20,
   parameter DATA_W = 16,
   parameter SECT_W = 5,
   parameter [15:0] SE_WIN_CYC = `FBEC_SE_WIN_US * `FBEC_CLK_MHZ,
   parameter [15:0] PROG_CYC = `FBEC_PROG_CYC,
   parameter [15:0] PREP_CYC = `FBEC_PREP_CYC,
   parameter [15:0] ERASE_CYC = `FBEC_ERASE_CYC
) (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Flash bus pins
   input wire ce_n_in,
   input wire we_n_in,
   input wire oe_n_in,
   input wire hw_reset_n_in,
   input wire accel_supply_pin_in,
   input wire [ADDR_W-1:0] addr_in,
   input wire [DATA_W-1:0] data_in,
   // Internal configuration
   input wire secured_region_in,
   input wire protection_lock_bit_in,
   input wire [(1<<SECT_W)-1:0] sector_prot_in,
   // Status
   output wire ready_busy_n_out,
   output wire inverted_data_poll_bit_out,
   output wire toggle_bit_one_out,
   output wire toggle_bit_two_out,
   output wire bypass_mode_out,
   output wire erase_suspended_out,
   output wire array_valid_out,
   // Array core requests
   output reg pgm_stb_out,
   output reg [ADDR_W-1:0] pgm_addr_out,
   output reg [DATA_W-1:0] pgm_data_out,
   output reg pgm_skip_prot_out,
   output reg [1:0] erase_phase_out,
   output reg [(1<<SECT_W)-1:0] erase_mask_out
);
   localparam NS = 1 << SECT_W;

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [3:0] S_READ = 4'h0;
   localparam [3:0] S_U1 = 4'h1;
   localparam [3:0] S_U2 = 4'h2;
   localparam [3:0] S_PSET = 4'h3;
   localparam [3:0] S_ESET = 4'h4;
   localparam [3:0] S_EU1 = 4'h5;
   localparam [3:0] S_EU2 = 4'h6;
   localparam [3:0] S_BYP = 4'h7;
   localparam [3:0] S_BPGM = 4'h8;
   localparam [3:0] S_BERS = 4'h9;
   localparam [3:0] S_BRST = 4'ha;
   localparam [3:0] S_ACC = 4'hb;
   localparam [3:0] S_SEWIN = 4'hc;
   localparam [3:0] S_PROG = 4'hd;
   localparam [3:0] S_ERASE = 4'he;
   localparam [3:0] S_SUSP = 4'hf;

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function match;
      input [ADDR_W-1:0] a;
      input [7:0] d;
      input [11:0] ea;
      input [7:0] ed;
      begin
         match = (a[11:0] == ea) && (d == ed);
      end
   endfunction

   function [SECT_W-1:0] sect_of;
      input [ADDR_W-1:0] a;
      begin
         sect_of = a[ADDR_W-1 -: SECT_W];
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   wire [4:0] ctl_s;
   wire [ADDR_W+DATA_W-1:0] bus_s;

   fbec_sync #(.W(5), .RST(5'h0f)) u_ctl_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .d_in({accel_supply_pin_in, hw_reset_n_in, oe_n_in, ce_n_in,
             we_n_in}),
      .q_out(ctl_s)
   );

   fbec_sync #(.W(ADDR_W+DATA_W)) u_bus_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .d_in({addr_in, data_in}),
      .q_out(bus_s)
   );

   wire we_s = ctl_s[0];
   wire ce_s = ctl_s[1];
   wire oe_s = ctl_s[2];
   wire hw_rst = ~ctl_s[3];
   wire acc_hv = ctl_s[4];
   wire [ADDR_W-1:0] addr_s = bus_s[ADDR_W+DATA_W-1:DATA_W];
   wire [DATA_W-1:0] data_s = bus_s[DATA_W-1:0];

   // ----------------------------------------
   // Strobe edges
   // ----------------------------------------
   // Write is active only while both strobes are low, so the falling
   // edge is the later of the two and the rising edge the earlier one.
   wire wr_act = ~ce_s & ~we_s;
   wire rd_act = ~ce_s & ~oe_s;
   reg wr_act_q;
   reg rd_act_q;
   wire wr_fall = wr_act & ~wr_act_q;
   wire wr_rise = ~wr_act & wr_act_q;
   wire rd_fall = rd_act & ~rd_act_q;
   wire abort = rst_in | hw_rst;

   reg [3:0] state_q;
   reg [ADDR_W-1:0] wa_q;
   reg [15:0] cnt_q;
   reg byp_q;
   reg sect_mode_q;
   reg [NS-1:0] sel_q;
   reg poll_q;
   reg tog1_q;
   reg tog2_q;
   reg valid_q;
   reg rel_q;
   reg [ADDR_W-1:0] hold_q;

   wire [7:0] cmd = data_s[7:0];
   wire busy = (state_q == S_PROG) || (state_q == S_ERASE) ||
               (state_q == S_SEWIN);
   wire cnt_done = (cnt_q == 16'h0000);
   wire [SECT_W-1:0] wsect = sect_of(wa_q);
   wire u1_ok = match(wa_q, cmd, `FBEC_UNLK_A1, `FBEC_UNLK_D1);
   wire u2_ok = match(wa_q, cmd, `FBEC_UNLK_A2, `FBEC_UNLK_D2);
   wire [3:0] idle_st = byp_q ? S_BYP : S_READ;

   always @(posedge clk_in) begin
      if (rst_in) begin
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
         wa_q <= {ADDR_W{1'b0}};
      end else begin
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
         if (wr_fall) begin
            wa_q <= addr_s; // [R17]
         end
      end
   end

   // ----------------------------------------
   // Command sequencer
   // ----------------------------------------
   always @(posedge clk_in) begin
      pgm_stb_out <= 1'b0;
      if (abort) begin
         state_q <= S_READ; // [R12]
         cnt_q <= 16'h0000;
         byp_q <= 1'b0;
         sect_mode_q <= 1'b0;
         sel_q <= {NS{1'b0}};
         poll_q <= 1'b0;
         pgm_addr_out <= {ADDR_W{1'b0}};
         pgm_data_out <= {DATA_W{1'b0}};
         pgm_skip_prot_out <= 1'b0;
         erase_phase_out <= `FBEC_PH_IDLE;
         erase_mask_out <= {NS{1'b0}};
      end else begin
         case (state_q)
            S_READ: begin
               if (wr_rise) begin
                  if (acc_hv && !secured_region_in &&
                      cmd == `FBEC_CMD_ACC) begin
                     state_q <= S_ACC; // [R2] [R4]
                  end else if (u1_ok) begin
                     state_q <= S_U1;
                  end else begin
                     state_q <= S_READ; // [R24]
                  end
               end
            end
            S_U1: begin
               if (wr_rise) begin
                  state_q <= u2_ok ? S_U2 : S_READ; // [R24]
               end
            end
            S_U2: begin
               if (wr_rise) begin
                  if (wa_q[11:0] != `FBEC_UNLK_A1) begin
                     state_q <= S_READ; // [R24]
                  end else if (cmd == `FBEC_CMD_BYP) begin
                     // [R5] [R9]
                     state_q <= S_READ;
                     byp_q <= ~secured_region_in;
                     if (!secured_region_in) begin
                        state_q <= S_BYP;
                     end
                  end else if (cmd == `FBEC_CMD_PGM) begin
                     state_q <= S_PSET; // [R23]
                  end else if (cmd == `FBEC_CMD_ESET) begin
                     state_q <= S_ESET; // [R10]
                  end else begin
                     state_q <= S_READ; // [R24]
                  end
               end
            end
            S_ESET: begin
               if (wr_rise) begin
                  state_q <= u1_ok ? S_EU1 : S_READ; // [R10]
               end
            end
            S_EU1: begin
               if (wr_rise) begin
                  state_q <= u2_ok ? S_EU2 : S_READ; // [R10]
               end
            end
            S_EU2: begin
               if (wr_rise) begin
                  poll_q <= 1'b0;
                  if (match(wa_q, cmd, `FBEC_UNLK_A1, `FBEC_CMD_CHIP)) begin
                     // Erase begins on this rising edge [R13] [R11]
                     state_q <= S_ERASE;
                     sect_mode_q <= 1'b0;
                     erase_mask_out <= ~sector_prot_in;
                     erase_phase_out <= `FBEC_PH_PREP;
                     cnt_q <= PREP_CYC;
                  end else if (cmd == `FBEC_CMD_SECT) begin
                     state_q <= S_SEWIN; // [R17]
                     sect_mode_q <= 1'b1;
                     sel_q <= {NS{1'b0}} | ({{(NS-1){1'b0}}, 1'b1} << wsect);
                     cnt_q <= 16'h0000;
                  end else begin
                     state_q <= S_READ; // [R24]
                  end
               end
            end
            S_BYP: begin
               if (wr_rise) begin
                  if (cmd == `FBEC_CMD_PGM && acc_hv &&
                      !secured_region_in) begin
                     state_q <= S_ACC; // [R2]
                  end else if (cmd == `FBEC_CMD_PGM &&
                               !secured_region_in) begin
                     state_q <= S_BPGM; // [R6] [R9]
                  end else if (cmd == `FBEC_CMD_ESET) begin
                     state_q <= S_BERS; // [R8]
                  end else if (cmd == `FBEC_CMD_BRST1) begin
                     state_q <= S_BRST; // [R7]
                  end
               end
            end
            S_BERS: begin
               if (wr_rise) begin
                  if (cmd == `FBEC_CMD_CHIP) begin
                     // No suspend: sect_mode_q stays clear [R8] [R13]
                     state_q <= S_ERASE;
                     sect_mode_q <= 1'b0;
                     poll_q <= 1'b0;
                     erase_mask_out <= ~sector_prot_in; // [R11]
                     erase_phase_out <= `FBEC_PH_PREP;
                     cnt_q <= PREP_CYC;
                  end else begin
                     state_q <= S_BYP; // [R24]
                  end
               end
            end
            S_BRST: begin
               if (wr_rise) begin
                  if (cmd == `FBEC_CMD_BRST2) begin
                     state_q <= S_READ; // [R7]
                     byp_q <= 1'b0;
                  end else begin
                     state_q <= S_BYP;
                  end
               end
            end
            S_PSET, S_BPGM, S_ACC: begin
               if (wr_rise) begin
                  // Accelerated path bypasses protection unless lock bit set [R3]
                  if ((state_q == S_ACC && !protection_lock_bit_in) ||
                      !sector_prot_in[wsect]) begin
                     pgm_stb_out <= 1'b1; // [R6] [R23]
                     pgm_addr_out <= wa_q;
                     pgm_data_out <= data_s;
                     pgm_skip_prot_out <= (state_q == S_ACC) &&
                                          !protection_lock_bit_in;
                     poll_q <= ~data_s[7];
                     cnt_q <= PROG_CYC;
                     state_q <= S_PROG;
                  end else begin
                     state_q <= idle_st;
                  end
               end
            end
            S_SEWIN: begin
               // Timer restarts on both edges of every write [R19]
               if (wr_fall || wr_act) begin
                  cnt_q <= 16'h0000;
               end else if (cnt_q == SE_WIN_CYC - 16'h0001) begin
                  state_q <= S_ERASE; // [R19]
                  erase_mask_out <= sel_q & ~sector_prot_in; // [R21]
                  erase_phase_out <= `FBEC_PH_PREP;
                  cnt_q <= PREP_CYC;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
               if (wr_rise) begin
                  if (cmd == `FBEC_CMD_SECT) begin
                     sel_q <= sel_q | ({{(NS-1){1'b0}}, 1'b1} << wsect);
                     cnt_q <= 16'h0000; // [R18]
                  end else if (cmd == `FBEC_CMD_SUSP) begin
                     state_q <= S_SUSP;
                     erase_mask_out <= sel_q & ~sector_prot_in;
                     erase_phase_out <= `FBEC_PH_PREP;
                     cnt_q <= PREP_CYC;
                  end else begin
                     state_q <= S_READ; // [R24]
                     sel_q <= {NS{1'b0}};
                  end
               end
            end
            S_PROG: begin
               if (cnt_done) begin
                  state_q <= idle_st;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            S_ERASE: begin
               // Suspend only in sector erase; all else ignored [R15] [R22]
               if (wr_rise && sect_mode_q && cmd == `FBEC_CMD_SUSP) begin
                  state_q <= S_SUSP;
               end else if (!cnt_done) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else if (erase_phase_out == `FBEC_PH_PREP) begin
                  erase_phase_out <= `FBEC_PH_ERASE; // [R11]
                  cnt_q <= ERASE_CYC;
               end else begin
                  state_q <= idle_st;
                  erase_phase_out <= `FBEC_PH_IDLE;
                  erase_mask_out <= {NS{1'b0}};
                  sel_q <= {NS{1'b0}};
                  sect_mode_q <= 1'b0;
               end
            end
            S_SUSP: begin
               if (wr_rise && cmd == `FBEC_CMD_RESUME &&
                   !secured_region_in) begin
                  state_q <= S_ERASE; // [R22]
               end
            end
            default: begin
               state_q <= S_READ;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Status bits and array-valid tracking
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (abort) begin
         tog1_q <= 1'b0;
         tog2_q <= 1'b0;
         valid_q <= 1'b1;
         rel_q <= 1'b0;
         hold_q <= {ADDR_W{1'b0}};
      end else begin
         // Toggle one advances per read while a program or erase runs [R14]
         if (rd_fall && (state_q == S_PROG || state_q == S_ERASE)) begin
            tog1_q <= ~tog1_q;
         end
         if (rd_fall && sect_mode_q && sel_q[sect_of(addr_s)] &&
             (state_q == S_ERASE || state_q == S_SUSP)) begin
            tog2_q <= ~tog2_q; // [R14]
         end
         // Data stays invalid until the address moves on [R16]
         if (state_q == S_PROG || state_q == S_ERASE) begin
            valid_q <= 1'b0;
            rel_q <= 1'b1;
            hold_q <= addr_s;
         end else if (rel_q && addr_s != hold_q) begin
            valid_q <= 1'b1;
            rel_q <= 1'b0;
         end
      end
   end

   assign ready_busy_n_out = ~busy; // [R14]
   assign inverted_data_poll_bit_out = busy & poll_q;
   assign toggle_bit_one_out = tog1_q;
   assign toggle_bit_two_out = tog2_q;
   assign bypass_mode_out = byp_q;
   assign erase_suspended_out = (state_q == S_SUSP);
   assign array_valid_out = valid_q & ~busy;
endmodule

// file: fbec_decoder_sva.sv
// Port-level assertions for the command decoder
`timescale 1ns/1ps
module fbec_decoder_sva #(
   parameter SECT_W = 5
) (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Observed pins and status
   input wire hw_reset_n_in,
   input wire [(1<<SECT_W)-1:0] sector_prot_in,
   input wire ready_busy_n_out,
   input wire inverted_data_poll_bit_out,
   input wire toggle_bit_one_out,
   input wire bypass_mode_out,
   input wire erase_suspended_out,
   input wire array_valid_out,
   input wire pgm_stb_out,
   input wire [1:0] erase_phase_out,
   input wire [(1<<SECT_W)-1:0] erase_mask_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   chk_stb_once:
      assert property (pgm_stb_out |=> !pgm_stb_out)
      else $error("Program strobe held past one cycle");
   chk_stb_busy:
      assert property (pgm_stb_out |-> !ready_busy_n_out)
      else $error("Program started without busy");
   chk_erase_busy:
      assert property (erase_phase_out != 2'h0 && !erase_suspended_out |->
         !ready_busy_n_out && !inverted_data_poll_bit_out)
      else $error("Erase running without busy status");
   chk_prep_first:
      assert property (erase_phase_out == 2'h2 &&
         $past(erase_phase_out) != 2'h2 |-> $past(erase_phase_out) == 2'h1)
      else $error("Erase phase entered without preprogram");
   chk_prot_spared:
      assert property (erase_phase_out != 2'h0 |->
         (erase_mask_out & sector_prot_in) == '0)
      else $error("Protected sector selected for erase");
   chk_hw_abort:
      assert property (!hw_reset_n_in [*4] |-> erase_phase_out == 2'h0 &&
         ready_busy_n_out && !bypass_mode_out)
      else $error("Hardware reset did not abort");
   chk_toggle_hold:
      assert property (ready_busy_n_out && $past(ready_busy_n_out) &&
         !erase_suspended_out |-> $stable(toggle_bit_one_out))
      else $error("Toggle bit moved while idle");
   chk_valid_after:
      assert property ($rose(ready_busy_n_out) && hw_reset_n_in &&
         !erase_suspended_out |-> !array_valid_out)
      else $error("Array valid right after operation end");
endmodule

bind fbec_decoder fbec_decoder_sva #(.SECT_W(SECT_W)) fbec_decoder_sva_inst (
   .clk_in(clk_in),
   .rst_in(rst_in),
   .hw_reset_n_in(hw_reset_n_in),
   .sector_prot_in(sector_prot_in),
   .ready_busy_n_out(ready_busy_n_out),
   .inverted_data_poll_bit_out(inverted_data_poll_bit_out),
   .toggle_bit_one_out(toggle_bit_one_out),
   .bypass_mode_out(bypass_mode_out),
   .erase_suspended_out(erase_suspended_out),
   .array_valid_out(array_valid_out),
   .pgm_stb_out(pgm_stb_out),
   .erase_phase_out(erase_phase_out),
   .erase_mask_out(erase_mask_out)
);

// file: fbec_host.sv
// Host bus model driving write and read cycles on the flash pins
`timescale 1ns/1ps
module fbec_host (
   // Clock
   input wire clk_in,
   // Flash bus pins
   output logic ce_n_out,
   output logic we_n_out,
   output logic oe_n_out,
   output logic [19:0] addr_out,
   output logic [15:0] data_out
);
   initial begin
      ce_n_out = 1'b1;
      we_n_out = 1'b1;
      oe_n_out = 1'b1;
      addr_out = 20'h00000;
      data_out = 16'h0000;
   end

   // Strobes held three clocks low and high to clear the synchronisers
   task automatic wr(input logic [19:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      data_out <= d;
      ce_n_out <= 1'b0;
      we_n_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      ce_n_out <= 1'b1;
      we_n_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      // Released bus shows the inverse so stale data never matches
      data_out <= ~d;
   endtask

   task automatic rd(input logic [19:0] a);
      @(posedge clk_in);
      addr_out <= a;
      ce_n_out <= 1'b0;
      oe_n_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      ce_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      repeat (3) @(posedge clk_in);
   endtask

   task automatic unlock();
      wr(20'h00555, 16'h00aa);
      wr(20'h002aa, 16'h0055);
   endtask
endmodule

// file: flash_bypass_erase_cmd_decoder_bench.sv
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module flash_bypass_erase_cmd_decoder_bench;
   logic clk_in, rst_in, hw_reset_n, accel, secured, lock_bit;
   logic [31:0] prot;
   wire ce_n, we_n, oe_n, rdy_n, poll, tog1, tog2, byp, susp, valid;
   wire stb, skip;
   wire [19:0] addr, paddr;
   wire [15:0] data, pdata;
   wire [1:0] phase;
   wire [31:0] mask;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [36:0] exp_q[$];
   logic [36:0] e;
   logic t;

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   fbec_host fbec_host_inst (.clk_in(clk_in), .ce_n_out(ce_n),
      .we_n_out(we_n), .oe_n_out(oe_n), .addr_out(addr), .data_out(data));

   fbec_decoder #(.SE_WIN_CYC(16'd60), .PROG_CYC(16'd10),
      .PREP_CYC(16'd40), .ERASE_CYC(16'd40)) fbec_decoder_inst (
      .clk_in(clk_in), .rst_in(rst_in), .ce_n_in(ce_n), .we_n_in(we_n),
      .oe_n_in(oe_n), .hw_reset_n_in(hw_reset_n),
      .accel_supply_pin_in(accel), .addr_in(addr), .data_in(data),
      .secured_region_in(secured), .protection_lock_bit_in(lock_bit),
      .sector_prot_in(prot), .ready_busy_n_out(rdy_n),
      .inverted_data_poll_bit_out(poll), .toggle_bit_one_out(tog1),
      .toggle_bit_two_out(tog2), .bypass_mode_out(byp),
      .erase_suspended_out(susp), .array_valid_out(valid),
      .pgm_stb_out(stb), .pgm_addr_out(paddr), .pgm_data_out(pdata),
      .pgm_skip_prot_out(skip), .erase_phase_out(phase),
      .erase_mask_out(mask));

   task automatic results();
      if (error_cnt == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [36:0] x, y);
      num_checks++;
      if (y !== x) begin
         $display("Error %s expected %h seen %h", n, x, y);
         error_cnt++;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic wait_st(input logic [1:0] p, input logic rb);
      int n;
      n = 0;
      while (!(phase === p && rdy_n === rb) && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      chk("wait_state", 1, n < 3000);
   endtask

   // Program word with random data; ok says whether it must be taken
   task automatic prog(input logic [19:0] a, input logic sk, ok);
      logic [15:0] d;
      d = 16'($urandom) | 16'h0001;
      if (ok)
         exp_q.push_back({sk, a, d});
      fbec_host_inst.wr(a, d);
      tick(4);
      wait_st(2'h0, 1'b1);
   endtask

   function automatic logic [19:0] ra(input logic [4:0] s);
      return {s, 15'($urandom)};
   endfunction

   // Reference model of the array core requests
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         results();
      end
      if (stb === 1'b1) begin
         if (exp_q.size() == 0)
            chk("pgm_unexpected", 0, 1);
         else begin
            e = exp_q.pop_front();
            chk("pgm_word", e, {skip, paddr, pdata});
            chk("poll_bit", !e[7], poll);
         end
      end
   end

   initial begin
      e = $urandom(32'h5a1b);
      rst_in = 1'b1;
      hw_reset_n = 1'b1;
      {accel, secured, lock_bit} = 3'b000;
      prot = 32'h0000_0080;
      tick(3);
      rst_in <= 1'b0;
      tick(2);
      chk("reset_state", 5'h11, {rdy_n, byp, phase, valid});
      repeat (2) begin
         fbec_host_inst.unlock();
         fbec_host_inst.wr(20'h00555, 16'h00a0);
         prog(ra(5'd2), 1'b0, 1'b1);
         chk("valid_low", 0, valid);
         fbec_host_inst.rd(ra(5'd4));
         chk("valid_high", 1, valid);
      end
      fbec_host_inst.unlock();
      fbec_host_inst.wr(20'h00555, 16'h0020);
      tick(4);
      chk("bypass", 1, byp);
      repeat (3) begin
         fbec_host_inst.wr(20'h00000, 16'h00a0);
         prog(ra(5'd5), 1'b0, 1'b1);
      end
      fbec_host_inst.wr(20'h00000, 16'h0080);
      fbec_host_inst.wr(20'h00000, 16'h0010);
      wait_st(2'h1, 1'b0);
      chk("chip_mask", 32'(~prot), mask);
      fbec_host_inst.wr(20'h00000, 16'h00b0);
      tick(4);
      chk("no_suspend", 0, susp);
      wait_st(2'h0, 1'b1);
      chk("bypass_kept", 1, byp);
      secured <= 1'b1;
      fbec_host_inst.wr(20'h00000, 16'h00a0);
      prog(ra(5'd5), 1'b0, 1'b0);
      secured <= 1'b0;
      fbec_host_inst.wr(20'h12345, 16'h0090);
      fbec_host_inst.wr(20'h6789a, 16'h0000);
      tick(4);
      chk("bypass_exit", 0, byp);
      secured <= 1'b1;
      fbec_host_inst.unlock();
      fbec_host_inst.wr(20'h00555, 16'h0020);
      tick(4);
      chk("bypass_secured", 0, byp);
      @(posedge clk_in);
      accel <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         secured <= (i == 3);
         lock_bit <= (i != 0);
         fbec_host_inst.wr(20'h00000, 16'h00a0);
         prog(ra(i == 2 ? 5'd6 : 5'd7), i == 0, i % 2 == 0);
      end
      accel <= 1'b0;
      secured <= 1'b0;
      fbec_host_inst.wr(20'h00555, 16'h00aa);
      fbec_host_inst.wr(20'h002aa, 16'h0012);
      fbec_host_inst.wr(20'h00555, 16'h00a0);
      prog(ra(5'd2), 1'b0, 1'b0);
      for (int k = 0; k < 2; k++) begin
         fbec_host_inst.unlock();
         fbec_host_inst.wr(20'h00555, 16'h0080);
         fbec_host_inst.unlock();
         fbec_host_inst.wr(20'h00555, 16'h0010);
         wait_st(2'h1, 1'b0);
         chk("chip_mask", 32'(~prot), mask);
         if (k == 1) begin
            hw_reset_n <= 1'b0;
            tick(5);
            chk("hw_abort", 4'h8, {rdy_n, phase, byp});
            hw_reset_n <= 1'b1;
         end else begin
            t = tog1;
            fbec_host_inst.rd(ra(5'd1));
            chk("toggle_one", !t, tog1);
            fbec_host_inst.wr(20'h00555, 16'h00a0);
            prog(ra(5'd2), 1'b0, 1'b0);
            wait_st(2'h0, 1'b1);
         end
      end
      tick(3);
      fbec_host_inst.unlock();
      fbec_host_inst.wr(20'h00555, 16'h0080);
      fbec_host_inst.unlock();
      for (int s = 3; s < 12; s += 4)
         fbec_host_inst.wr(ra(5'(s)), 16'h0030);
      tick(20);
      chk("window", 3'h0, {rdy_n, phase});
      wait_st(2'h1, 1'b0);
      chk("sect_mask", 32'h0000_0808, mask);
      t = tog2;
      fbec_host_inst.rd(ra(5'd3));
      chk("toggle_two", !t, tog2);
      repeat (2) begin
         fbec_host_inst.wr(20'h00000, 16'h00b0);
         tick(4);
         chk("suspend", 1, susp);
         fbec_host_inst.wr(ra(5'd3), 16'h0030);
         tick(4);
         chk("resume", 0, susp);
      end
      wait_st(2'h0, 1'b1);
      chk("mask_clear", 0, mask);
      chk("pending", 0, exp_q.size());
      results();
   end
endmodule
